// file: design/rxcfs_pkg.sv
// What this block does
// - Match pause DA against configured 48-bit address
// - Pause address ignored for ordinary frames
// - First line byte sits in address LSB
// - Bits 31:16 give maximum frame size
// - Bit 14 enforces configured maximum size
// - Bit 10 low: answer faults per standard
// - Bit 10 high: always forward MAC data
// - Bit 9 skips control frame length check
// - Bit 8 high skips length/type checks
// - Bit 7 keeps preamble on delivered frame
// - Bit 5 pause frames pause transmitter
// - Bit 4 low limits legal maximum length unless bit 14 set
// - FCS always checked; bit 3 passes it
// - Bit 2 accepts VLAN tagged frames
// - Bit 1 enables the receiver
// - Bit 0 holds receiver in reset
// - Status bit 1 shows remote fault
// - Status bit 0 shows local fault
package rxcfs_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] ADDR_PAUSE_LO = 12'h000;
  localparam logic [11:0] ADDR_PAUSE_HI = 12'h004;
  localparam logic [11:0] ADDR_CTRL = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;

  // ==========================================================
  // Reset values and write masks
  localparam logic [31:0] PAUSE_LO_RST = 32'h00000000;
  localparam logic [15:0] PAUSE_HI_RST = 16'h0000;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] CTRL_WMASK = 32'hFFFF47BF;

  // ==========================================================
  // Status bit positions
  localparam int ST_LOCAL = 0;
  localparam int ST_REMOTE = 1;
  localparam int ST_BUSY = 2;

  // ==========================================================
  // Frame constants
  localparam logic [15:0] MAX_LEGAL = 16'h05EE;
  localparam logic [15:0] MAX_VLAN = 16'h05F2;
  localparam logic [15:0] MAX_LEN_FIELD = 16'h05DC;
  localparam logic [15:0] MIN_FRAME = 16'h0040;
  localparam logic [15:0] MIN_DATA = 16'h002E;
  localparam logic [15:0] HDR_BYTES = 16'h0012;
  localparam logic [15:0] VLAN_BYTES = 16'h0004;
  localparam logic [15:0] TYPE_VLAN = 16'h8100;
  localparam logic [15:0] TYPE_CTL = 16'h8808;
  localparam logic [15:0] OP_PAUSE = 16'h0001;
  localparam logic [47:0] MC_PAUSE = 48'h010000C28001;

  // Byte positions counted from the first preamble byte
  localparam logic [15:0] PRE_LEN = 16'h0008;
  localparam logic [15:0] DA_END = 16'h000D;
  localparam logic [15:0] LT_POS = 16'h0014;
  localparam logic [15:0] OP_POS = 16'h0016;
  localparam logic [15:0] QT_POS = 16'h0018;
  localparam logic [15:0] VLT_POS = 16'h0018;
  localparam logic [15:0] FCS_LEN = 16'h0004;

  // ==========================================================
  // Reconciliation transmit selection codes
  localparam logic [1:0] RS_DATA = 2'h0;
  localparam logic [1:0] RS_REMOTE = 2'h1;
  localparam logic [1:0] RS_IDLE = 2'h2;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [47:0] pause_addr;
    logic [15:0] receive_max_frame_size;
    logic rsv15;
    logic receive_max_size_override;
    logic [2:0] rsv13_11;
    logic fault_inhibit;
    logic ctl_len_dis;
    logic lt_dis;
    logic keep_pre;
    logic rsv6;
    logic fc_en;
    logic jumbo;
    logic fcs_pass;
    logic vlan_en;
    logic rx_en;
    logic rx_rst;
  } rxcfs_cfg_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
    logic good;
    logic filtered;
  } rxcfs_beat_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_FRAME = 3'b010,
    RX_FLUSH = 3'b100
  } rxcfs_state_t;

endpackage

// file: design/rxcfs_top.sv
`timescale 1ns/10ps
module rxcfs_top (
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Received byte stream from the decoder
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_sof,
  input wire logic in_eof,
  input wire logic in_fcs_ok,
  // Fault ordered sets seen by the decoder
  input wire logic rs_local_fault,
  input wire logic rs_remote_fault,
  // Delivered stream to the client
  output rxcfs_pkg::rxcfs_beat_t out_beat,
  // Pause request towards the transmitter
  output logic pause_req,
  output logic [15:0] pause_quanta,
  // Reconciliation transmit selection
  output logic [1:0] rs_tx_sel
);

  // ==========================================================
  // Registers
  logic [31:0] pause_lo_q;
  logic [15:0] pause_hi_q;
  logic [31:0] ctrl_q;
  logic [1:0] fault_q; // Fault levels, one cycle late
  rxcfs_pkg::rxcfs_state_t state_q; // Frame walker state, read back too
  rxcfs_pkg::rxcfs_cfg_t cfg; // Unpacked view of config

  assign cfg = {pause_hi_q, pause_lo_q, ctrl_q};

  // Receive path holds
  logic rx_hold; // Receive logic in reset
  assign rx_hold = !rst_n || cfg.rx_rst;

  // ==========================================================
  // APB slave
  logic acc; // Access phase awaiting answer
  logic wr_ok; // Write takes effect this edge
  logic [31:0] wmerge; // Byte-lane merge helper
  logic mapped; // Address decodes
  logic [31:0] pause_hi_w; // High address word as a full bus word

  assign pause_hi_w = {16'h0000, pause_hi_q};

  assign acc = psel && penable && !pready;
  assign wr_ok = acc && pwrite && mapped;

  // Decode of the four words
  always_comb
  begin
    case (paddr)
      rxcfs_pkg::ADDR_PAUSE_LO: mapped = 1'b1;
      rxcfs_pkg::ADDR_PAUSE_HI: mapped = 1'b1;
      rxcfs_pkg::ADDR_CTRL: mapped = 1'b1;
      rxcfs_pkg::ADDR_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Byte enables pick new or old bytes
  always_comb
  begin
    wmerge = 32'h00000000;
    for (int i = 0; i < 4; i++)
    begin
      case (paddr)
        rxcfs_pkg::ADDR_PAUSE_LO:
          wmerge[8*i +: 8] = pstrb[i] ? pwdata[8*i +: 8]
                                      : pause_lo_q[8*i +: 8];
        rxcfs_pkg::ADDR_PAUSE_HI:
          wmerge[8*i +: 8] = pstrb[i] ? pwdata[8*i +: 8]
                                      : pause_hi_w[8*i +: 8];
        default:
          wmerge[8*i +: 8] = pstrb[i] ? pwdata[8*i +: 8]
                                      : ctrl_q[8*i +: 8];
      endcase
    end
  end

  // One wait state: answer in the cycle after access starts
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= acc;
      pslverr <= acc && !mapped; // Unmapped address errors
    end
  end

  // Configuration words; status is read-only
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pause_lo_q <= rxcfs_pkg::PAUSE_LO_RST;
      pause_hi_q <= rxcfs_pkg::PAUSE_HI_RST;
      ctrl_q <= rxcfs_pkg::CTRL_RST;
    end
    else if (wr_ok)
    begin
      case (paddr)
        rxcfs_pkg::ADDR_PAUSE_LO: pause_lo_q <= wmerge;
        rxcfs_pkg::ADDR_PAUSE_HI: pause_hi_q <= wmerge[15:0];
        // Reserved control bits never stored
        rxcfs_pkg::ADDR_CTRL:
          ctrl_q <= wmerge & rxcfs_pkg::CTRL_WMASK;
        default: ; // Status write ignored
      endcase
    end
  end

  // Read data sampled with the answer
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      prdata <= 32'h00000000;
    else if (acc && !pwrite)
    begin
      case (paddr)
        rxcfs_pkg::ADDR_PAUSE_LO: prdata <= pause_lo_q;
        rxcfs_pkg::ADDR_PAUSE_HI: prdata <= pause_hi_w;
        rxcfs_pkg::ADDR_CTRL: prdata <= ctrl_q;
        rxcfs_pkg::ADDR_STATUS:
          prdata <= {29'h00000000, state_q != rxcfs_pkg::RX_IDLE,
                     fault_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // Fault status and reconciliation response
  // Fault levels come from same-clock decode logic
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      fault_q <= 2'b00;
    else
    begin
      fault_q[rxcfs_pkg::ST_REMOTE] <= rs_remote_fault;
      fault_q[rxcfs_pkg::ST_LOCAL] <= rs_local_fault;
    end
  end

  // Local fault wins over remote, as the standard orders
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rs_tx_sel <= rxcfs_pkg::RS_DATA;
    else if (cfg.fault_inhibit)
      rs_tx_sel <= rxcfs_pkg::RS_DATA;
    else if (rs_local_fault)
      rs_tx_sel <= rxcfs_pkg::RS_REMOTE;
    else if (rs_remote_fault)
      rs_tx_sel <= rxcfs_pkg::RS_IDLE;
    else
      rs_tx_sel <= rxcfs_pkg::RS_DATA;
  end

  // ==========================================================
  // Receive frame walker
  logic [15:0] cnt_q; // Byte index from first preamble byte
  logic [2:0] fl_q; // Flush bytes left
  logic [7:0] dly_q [0:3]; // FCS-wide delay line
  logic start_ok; // New frame may begin
  logic [15:0] dly_idx; // Index of the byte leaving the line
  logic [15:0] first_out; // First delivered index

  // Disabled receiver ignores new frames
  assign start_ok = in_valid && in_sof && cfg.rx_en;
  assign dly_idx = cnt_q - rxcfs_pkg::FCS_LEN;
  // Preamble kept or dropped
  assign first_out = cfg.keep_pre ? 16'h0000 : rxcfs_pkg::PRE_LEN;

  // Frame state and byte index
  always_ff @(posedge core_clk)
  begin
    if (rx_hold)
    begin
      state_q <= rxcfs_pkg::RX_IDLE;
      cnt_q <= 16'h0000;
      fl_q <= 3'h0;
    end
    else
    begin
      case (state_q)
        rxcfs_pkg::RX_IDLE:
          if (start_ok)
          begin
            state_q <= rxcfs_pkg::RX_FRAME;
            cnt_q <= 16'h0001;
          end
        rxcfs_pkg::RX_FRAME:
          if (in_valid && in_eof)
          begin
            // Passed FCS drains the delay line
            state_q <= cfg.fcs_pass ? rxcfs_pkg::RX_FLUSH
                                    : rxcfs_pkg::RX_IDLE;
            fl_q <= 3'h4;
          end
          else if (in_valid && cnt_q != 16'hFFFF)
            cnt_q <= cnt_q + 16'h0001; // Saturates on huge frames
        rxcfs_pkg::RX_FLUSH:
        begin
          fl_q <= fl_q - 3'h1;
          if (fl_q == 3'h1)
            state_q <= rxcfs_pkg::RX_IDLE;
        end
        default: state_q <= rxcfs_pkg::RX_IDLE;
      endcase
    end
  end

  // Delay line shifts on each accepted byte or flush step
  always_ff @(posedge core_clk)
  begin
    if (rx_hold)
      for (int i = 0; i < 4; i++)
        dly_q[i] <= 8'h00;
    else if ((in_valid && (start_ok || state_q == rxcfs_pkg::RX_FRAME))
             || state_q == rxcfs_pkg::RX_FLUSH)
    begin
      dly_q[0] <= in_data;
      for (int i = 1; i < 4; i++)
        dly_q[i] <= dly_q[i-1];
    end
  end

  // ==========================================================
  // Header capture and checks
  logic [15:0] lt_q; // Length/type, after any tag
  logic [15:0] op_q; // Control opcode
  logic [15:0] qt_q; // Pause quanta
  logic tagged_q; // Frame carries a VLAN tag
  logic da_own_q; // DA matches configured address
  logic da_mc_q; // DA matches pause multicast
  logic [5:0] da_off; // Bit offset of current DA byte
  logic in_hdr; // Byte belongs to this frame

  assign in_hdr = in_valid && state_q == rxcfs_pkg::RX_FRAME;
  assign da_off = 6'(({3'h0, cnt_q[2:0]} - 6'h08) << 3);

  // Destination compare, first line byte at LSB
  always_ff @(posedge core_clk)
  begin
    if (rx_hold || start_ok)
    begin
      da_own_q <= 1'b1;
      da_mc_q <= 1'b1;
    end
    else if (in_hdr && cnt_q >= rxcfs_pkg::PRE_LEN
             && cnt_q <= rxcfs_pkg::DA_END)
    begin
      // Configured address only feeds pause decode
      if (in_data != cfg.pause_addr[da_off +: 8])
        da_own_q <= 1'b0;
      if (in_data != rxcfs_pkg::MC_PAUSE[da_off +: 8])
        da_mc_q <= 1'b0;
    end
  end

  // Length/type, opcode and quanta fields
  always_ff @(posedge core_clk)
  begin
    if (rx_hold || start_ok)
    begin
      lt_q <= 16'h0000;
      op_q <= 16'h0000;
      qt_q <= 16'h0000;
      tagged_q <= 1'b0;
    end
    else if (in_hdr)
    begin
      if (cnt_q == rxcfs_pkg::LT_POS)
        lt_q[15:8] <= in_data;
      if (cnt_q == rxcfs_pkg::LT_POS + 16'h0001)
      begin
        lt_q[7:0] <= in_data;
        tagged_q <= {lt_q[15:8], in_data} == rxcfs_pkg::TYPE_VLAN;
      end
      // Inner type replaces the tag type
      if (tagged_q && cnt_q == rxcfs_pkg::VLT_POS)
        lt_q[15:8] <= in_data;
      if (tagged_q && cnt_q == rxcfs_pkg::VLT_POS + 16'h0001)
        lt_q[7:0] <= in_data;
      if (cnt_q == rxcfs_pkg::OP_POS)
        op_q[15:8] <= in_data;
      if (cnt_q == rxcfs_pkg::OP_POS + 16'h0001)
        op_q[7:0] <= in_data;
      if (cnt_q == rxcfs_pkg::QT_POS)
        qt_q[15:8] <= in_data;
      if (cnt_q == rxcfs_pkg::QT_POS + 16'h0001)
        qt_q[7:0] <= in_data;
    end
  end

  // End-of-frame verdict, valid in the eof cycle
  logic [15:0] flen; // Length DA..FCS
  logic [15:0] dlen; // Client data bytes
  logic [15:0] max_len; // Active size limit
  logic is_ctl; // Control type frame
  logic len_bad, lt_bad, ctl_bad, vlan_bad;
  logic good, pause_hit;

  assign flen = cnt_q + 16'h0001 - rxcfs_pkg::PRE_LEN;
  assign dlen = flen - rxcfs_pkg::HDR_BYTES
                - (tagged_q ? rxcfs_pkg::VLAN_BYTES : 16'h0000);
  assign is_ctl = !tagged_q && lt_q == rxcfs_pkg::TYPE_CTL;

  // Size limit selection
  always_comb
  begin
    max_len = (tagged_q && cfg.vlan_en) ? rxcfs_pkg::MAX_VLAN
                                        : rxcfs_pkg::MAX_LEGAL;
    len_bad = 1'b0;
    if (cfg.receive_max_size_override)
      len_bad = flen > cfg.receive_max_frame_size;
    else if (!cfg.jumbo)
      len_bad = flen > max_len;
  end

  // Length field versus data; short field implies padding
  always_comb
  begin
    lt_bad = 1'b0;
    if (!cfg.lt_dis && lt_q <= rxcfs_pkg::MAX_LEN_FIELD)
    begin
      if (lt_q < rxcfs_pkg::MIN_DATA)
        lt_bad = flen != rxcfs_pkg::MIN_FRAME;
      else
        lt_bad = lt_q != dlen;
    end
  end

  assign ctl_bad = is_ctl && !cfg.ctl_len_dis
                   && flen > rxcfs_pkg::MIN_FRAME;
  assign vlan_bad = tagged_q && !cfg.vlan_en;
  // FCS verdict always counts
  assign good = in_fcs_ok && !len_bad && !lt_bad && !ctl_bad
                && !vlan_bad;
  // Address match only decides pause handling
  assign pause_hit = good && is_ctl && op_q == rxcfs_pkg::OP_PAUSE
                     && (da_own_q || da_mc_q);

  // ==========================================================
  // Client output
  logic good_q; // Verdict held over the flush
  logic filt_q; // Frame consumed by flow control

  always_ff @(posedge core_clk)
  begin
    if (rx_hold)
    begin
      good_q <= 1'b0;
      filt_q <= 1'b0;
    end
    else if (in_hdr && in_eof)
    begin
      good_q <= good;
      filt_q <= pause_hit && cfg.fc_en;
    end
  end

  // Byte leaves the line once four newer bytes follow it
  always_ff @(posedge core_clk)
  begin
    if (rx_hold)
      out_beat <= '0;
    else
    begin
      out_beat <= '0;
      out_beat.data <= dly_q[3];
      if (in_hdr && cnt_q >= rxcfs_pkg::FCS_LEN
          && dly_idx >= first_out)
      begin
        out_beat.valid <= 1'b1;
        if (in_eof && !cfg.fcs_pass)
        begin
          // FCS stripped: last data byte ends frame
          out_beat.last <= 1'b1;
          out_beat.good <= good;
          out_beat.filtered <= pause_hit && cfg.fc_en;
        end
      end
      else if (state_q == rxcfs_pkg::RX_FLUSH)
      begin
        out_beat.valid <= 1'b1;
        if (fl_q == 3'h1)
        begin
          out_beat.last <= 1'b1;
          out_beat.good <= good_q;
          out_beat.filtered <= filt_q;
        end
      end
    end
  end

  // ==========================================================
  // Pause request towards the transmitter
  always_ff @(posedge core_clk)
  begin
    if (rx_hold)
    begin
      pause_req <= 1'b0;
      pause_quanta <= 16'h0000;
    end
    else
    begin
      pause_req <= in_hdr && in_eof && pause_hit
                   && cfg.fc_en;
      if (in_hdr && in_eof && pause_hit)
        pause_quanta <= qt_q;
    end
  end

endmodule

// file: dv/rxcfs_properties.sv
`timescale 1ns/10ps
// ==========================================
// Port checker for the receive config block
module rxcfs_properties (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_sof,
  input wire logic in_eof,
  input wire logic in_fcs_ok,
  input wire logic rs_local_fault,
  input wire logic rs_remote_fault,
  input wire rxcfs_pkg::rxcfs_beat_t out_beat,
  input wire logic pause_req,
  input wire logic [15:0] pause_quanta,
  input wire logic [1:0] rs_tx_sel
);
  logic [31:0] ctrl_q; // Shadow of the control word
  logic mapped; // Address hits one of the four registers
  logic wr_ctrl; // Control write taken this edge
  assign mapped = paddr inside {rxcfs_pkg::ADDR_PAUSE_LO,
    rxcfs_pkg::ADDR_PAUSE_HI, rxcfs_pkg::ADDR_CTRL, rxcfs_pkg::ADDR_STATUS};
  assign wr_ctrl = psel && penable && !pready && pwrite &&
    paddr == rxcfs_pkg::ADDR_CTRL;
  // Shadow follows the take edge; full strobes only, as the bench uses
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ctrl_q <= 32'h00000000;
    else if (wr_ctrl)
      ctrl_q <= pwdata & rxcfs_pkg::CTRL_WMASK;
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_take;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_apb_one_wait: assert property (s_take |=> s_answer)
    else $error("apb answer not after one wait");
  a_slverr_map: assert property (pready |-> pslverr == !mapped)
    else $error("slave error disagrees with map");
  a_status_read: assert property (pready && !pwrite && mapped &&
    paddr == rxcfs_pkg::ADDR_STATUS |-> prdata[1:0] ==
    $past({rs_remote_fault, rs_local_fault}, 2))
    else $error("status bits wrong");
  a_fault_local: assert property (!ctrl_q[10] && rs_local_fault |=>
    rs_tx_sel == rxcfs_pkg::RS_REMOTE) else $error("no remote fault sent");
  a_fault_remote: assert property (!ctrl_q[10] &&
    !rs_local_fault && rs_remote_fault |=> rs_tx_sel == rxcfs_pkg::RS_IDLE)
    else $error("no idle sent");
  a_fault_inhibit: assert property (ctrl_q[10] |=>
    rs_tx_sel == rxcfs_pkg::RS_DATA) else $error("inhibit ignored");
  a_rx_held: assert property (ctrl_q[0] |=>
    out_beat == '0 && !pause_req) else $error("receiver not held");
  a_pause_gate: assert property (pause_req |->
    ctrl_q[5] ##1 !pause_req) else $error("pause pulse wrong");
  a_good_last: assert property (
    out_beat.good || out_beat.filtered |-> out_beat.last && out_beat.valid)
    else $error("flag off last beat");
endmodule

bind rxcfs_top rxcfs_properties u_props (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .in_valid(in_valid), .in_data(in_data), .in_sof(in_sof),
  .in_eof(in_eof), .in_fcs_ok(in_fcs_ok), .rs_local_fault(rs_local_fault),
  .rs_remote_fault(rs_remote_fault), .out_beat(out_beat),
  .pause_req(pause_req), .pause_quanta(pause_quanta), .rs_tx_sel(rs_tx_sel)
);

// file: dv/rxcfs_frame_src.sv
`timescale 1ns/10ps
// ==========================================
// Decoder side: plays one stored frame per start pulse
module rxcfs_frame_src (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [15:0] len,
  input wire logic fcs_good,
  output logic in_valid,
  output logic [7:0] in_data,
  output logic in_sof,
  output logic in_eof,
  output logic in_fcs_ok,
  output logic busy
);
  logic [7:0] mem [0:2047]; // Frame bytes, first line byte first
  logic [15:0] idx_q; // Byte on the line now
  logic busy_q; // Frame in flight
  logic [7:0] held_q; // Last byte shown, inverted when idle
  // Bytes go back to back; the receiver would hold its count over a gap
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      busy_q <= 1'b0;
    else if (start && !busy_q)
      busy_q <= 1'b1;
    else if (busy_q && idx_q == len - 16'h0001)
      busy_q <= 1'b0;
  end
  // Byte index restarts whenever idle
  always_ff @(posedge core_clk)
  begin
    if (!busy_q)
      idx_q <= 16'h0000;
    else
      idx_q <= idx_q + 16'h0001;
  end
  // Remember the last byte so idle shows something else
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      held_q <= 8'h5A;
    else if (busy_q)
      held_q <= mem[idx_q];
  end
  assign busy = busy_q;
  assign in_valid = busy_q;
  assign in_sof = busy_q && idx_q == 16'h0000;
  assign in_eof = busy_q && idx_q == len - 16'h0001;
  assign in_data = busy_q ? mem[idx_q] : ~held_q;
  // Verdict only means something with the last byte
  assign in_fcs_ok = in_eof ? fcs_good : ~fcs_good;
endmodule

// file: dv/rxcfs_bench.sv
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, (a), (e)); \
  end end
// ==========================================
// Testbench top
module rxcfs_bench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF; // Full words only
  logic rs_local_fault = 1'b0;
  logic rs_remote_fault = 1'b0;
  logic start = 1'b0; // Kicks the byte source
  logic [15:0] len = 16'h0040;
  logic fcs_good = 1'b1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic in_valid;
  logic [7:0] in_data;
  logic in_sof;
  logic in_eof;
  logic in_fcs_ok;
  logic busy;
  rxcfs_pkg::rxcfs_beat_t out_beat;
  logic pause_req;
  logic [15:0] pause_quanta;
  logic [1:0] rs_tx_sel;
  int error_cnt = 0;
  int cmp_count = 0;
  int beats; // Delivered bytes of the current frame
  int pauses; // Pause pulses seen
  logic last_good; // Verdict on the last beat
  logic last_filt; // Filter mark on the last beat
  logic [7:0] first_b; // First delivered byte of the frame

  always #20 core_clk = ~core_clk;

  rxcfs_top dut (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_valid(in_valid), .in_data(in_data), .in_sof(in_sof),
    .in_eof(in_eof), .in_fcs_ok(in_fcs_ok),
    .rs_local_fault(rs_local_fault), .rs_remote_fault(rs_remote_fault),
    .out_beat(out_beat), .pause_req(pause_req),
    .pause_quanta(pause_quanta), .rs_tx_sel(rs_tx_sel)
  );
  rxcfs_frame_src src (
    .core_clk(core_clk), .rst_n(rst_n), .start(start), .len(len),
    .fcs_good(fcs_good), .in_valid(in_valid), .in_data(in_data),
    .in_sof(in_sof), .in_eof(in_eof), .in_fcs_ok(in_fcs_ok), .busy(busy)
  );

  // ==========================================
  // Client-side monitor of the delivered stream
  always @(posedge core_clk)
  begin
    if (out_beat.valid === 1'b1 && beats == 0)
      first_b = out_beat.data;
    if (out_beat.valid === 1'b1)
      beats++;
    if (out_beat.last === 1'b1)
    begin
      last_good = out_beat.good;
      last_filt = out_beat.filtered;
    end
    if (pause_req === 1'b1)
      pauses++;
  end

  // ==========================================
  // Verdict and hang handling
  task automatic complete_run;
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic timeout_hit;
    error_cnt++;
    $display("mismatch at %0t: wait ran out", $time);
    complete_run();
  endtask

  // One APB transfer; no cycle count assumed, waits on pready
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      timeout_hit();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x,
    input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    `CHK(r, x)
    `CHK(e, xe)
  endtask

  // Builds a frame (preamble, DA, SA, type, opcode, quanta) and plays it
  task automatic run_frame(input logic [31:0] c, input int n,
    input logic [15:0] typ, input logic hit, input logic fok, input int nb,
    input logic gd, input logic ps);
    int k;
    wr(rxcfs_pkg::ADDR_CTRL, c);
    for (k = 0; k < n + 8; k++)
      src.mem[k] = (k < 7) ? 8'h55 : (k == 7) ? 8'hD5 : 8'h00;
    for (k = 0; k < 6; k++)
      src.mem[8 + k] = hit ? 8'hAA + 8'h11 * k[7:0] : 8'h12;
    src.mem[20] = typ[15:8];
    src.mem[21] = typ[7:0];
    src.mem[23] = 8'h01;
    src.mem[24] = 8'h01;
    src.mem[25] = 8'h23;
    len <= n[15:0] + 16'h0008;
    fcs_good <= fok;
    beats = 0;
    pauses = 0;
    last_good = 1'b0;
    last_filt = 1'b0;
    first_b = 8'h00;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    @(posedge core_clk);
    for (k = 0; busy === 1'b1; k++)
    begin
      if (k > 2000)
        timeout_hit();
      @(posedge core_clk);
    end
    repeat (12) @(posedge core_clk);
    if (nb >= 0) `CHK(beats, nb)
    if (nb > 0) `CHK(last_filt, ps)
    if (nb > 0) `CHK(first_b, c[7] ? 8'h55 : hit ? 8'hAA : 8'h12)
    `CHK(last_good, gd)
    `CHK(pauses, ps ? 1 : 0)
    if (ps) `CHK(pause_quanta, 16'h0123)
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 4; i++)
      rd_chk(12'(i * 4), 32'h00000000, 1'b0);
    rd_chk(12'h010, 32'h00000000, 1'b1);
    wr(rxcfs_pkg::ADDR_CTRL, 32'hFFFFFFFF);
    rd_chk(rxcfs_pkg::ADDR_CTRL, rxcfs_pkg::CTRL_WMASK, 1'b0);
    wr(rxcfs_pkg::ADDR_STATUS, 32'hFFFFFFFF);
    rd_chk(rxcfs_pkg::ADDR_STATUS, 32'h00000000, 1'b0);
    wr(rxcfs_pkg::ADDR_PAUSE_LO, 32'hDDCCBBAA);
    wr(rxcfs_pkg::ADDR_PAUSE_HI, 32'h0000FFEE);
    rd_chk(rxcfs_pkg::ADDR_PAUSE_LO, 32'hDDCCBBAA, 1'b0);
    rd_chk(rxcfs_pkg::ADDR_PAUSE_HI, 32'h0000FFEE, 1'b0);
    // Fault answers, with and without inhibit
    wr(rxcfs_pkg::ADDR_CTRL, 32'h00000000);
    rs_local_fault <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK(rs_tx_sel, rxcfs_pkg::RS_REMOTE)
    rd_chk(rxcfs_pkg::ADDR_STATUS, 32'h00000001, 1'b0);
    rs_local_fault <= 1'b0;
    rs_remote_fault <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK(rs_tx_sel, rxcfs_pkg::RS_IDLE)
    rd_chk(rxcfs_pkg::ADDR_STATUS, 32'h00000002, 1'b0);
    wr(rxcfs_pkg::ADDR_CTRL, 32'h00000400);
    repeat (2) @(posedge core_clk);
    `CHK(rs_tx_sel, rxcfs_pkg::RS_DATA)
    rs_remote_fault <= 1'b0;
    // Frames: ctrl, length, type, DA hit, FCS ok, beats, good, pause
    run_frame(32'h002, 64, 16'h8808, 1, 1, 60, 1, 0);
    run_frame(32'h022, 64, 16'h8808, 1, 1, 60, 1, 1);
    run_frame(32'h022, 64, 16'h8808, 0, 1, 60, 1, 0);
    run_frame(32'h08A, 64, 16'h8808, 1, 1, 72, 1, 0);
    run_frame(32'h002, 64, 16'h8808, 1, 0, 60, 0, 0);
    run_frame(32'h000, 64, 16'h8808, 1, 1, 0, 0, 0);
    run_frame(32'h003, 64, 16'h8808, 1, 1, 0, 0, 0);
    run_frame(32'h002, 1530, 16'h0800, 1, 1, -1, 0, 0);
    run_frame(32'h012, 1530, 16'h0800, 1, 1, 1526, 1, 0);
    run_frame(32'h3F4002, 64, 16'h0800, 1, 1, -1, 0, 0);
    run_frame(32'h404002, 64, 16'h0800, 1, 1, 60, 1, 0);
    run_frame(32'h002, 68, 16'h8808, 0, 1, -1, 0, 0);
    run_frame(32'h202, 68, 16'h8808, 0, 1, 64, 1, 0);
    run_frame(32'h102, 64, 16'h8100, 0, 1, -1, 0, 0);
    run_frame(32'h106, 64, 16'h8100, 0, 1, 60, 1, 0);
    run_frame(32'h006, 64, 16'h8100, 0, 1, -1, 0, 0);
    complete_run();
  end
endmodule
